// ===== verilog/pgc_top.v
/*
 * Control and interrupt-status logic for one motor-control PWM generator:
 * pending flags with enables, period and duty source selection, and the
 * gating of dead-time compensation, center-aligned and external period reset.
 * Assumes a 100 MHz clock, an Avalon-MM master with waitrequest and
 * asynchronous event pins from the fault, current-limit and trigger logic.
 */
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

`include "pgc_map.vh"

// What this block does
// - fault pending flag set by hardware on fault event; reads 0 otherwise
// - current-limit pending flag set by hardware on limit event; else 0
// - trigger pending flag set by hardware on trigger event; else 0
// - fault enable 1 permits fault interrupts; writing 0 disables and clears flag
// - limit enable 1 permits limit interrupts; writing 0 disables and clears flag
// - trigger enable 1 lets triggers interrupt; writing 0 disables and clears flag
// - independent time base 1: period comes from the generator phase register
// - independent time base 0: period comes from the shared master period
// - dead-time polarity honoured only when dead-time control equals 11
// - center-aligned mode only takes effect with independent time base 1
// - external period reset needs independent time base 1 and limit mode 0
module pgc_top #(
    parameter DATA_W = 16
) (
    input wire CLK_I,
    input wire RST_I,
    input wire [5:0] AVS_ADDRESS_I,
    input wire AVS_READ_I,
    input wire AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire [3:0] AVS_BYTEENABLE_I,
    output wire [31:0] AVS_READDATA_O,
    output wire AVS_WAITREQUEST_O,
    input wire FAULT_EVT_I,
    input wire LIMIT_EVT_I,
    input wire TRIGGER_EVT_I,
    output wire [DATA_W-1:0] PERIOD_O,
    output wire [DATA_W-1:0] DUTY_O,
    output wire CENTER_ALIGNED_O,
    output wire EXT_PERIOD_RESET_O,
    output wire [1:0] DEADTIME_CONTROL_O,
    output wire DEADTIME_COMP_POL_O,
    output wire TIMEBASE_SOURCE_O,
    output wire IMMEDIATE_UPDATE_O,
    output wire PWM_MODULE_ENABLE_O,
    output wire IRQ_O
);

    // ---------------------------------------------------------------
    // event pins, synchronised and turned into one-cycle pulses
    // ---------------------------------------------------------------
    wire [2:0] evt_pulse;

    pgc_evt_sync #(
        .WIDTH(3)
    ) u_evt_sync (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .evt_i({TRIGGER_EVT_I, LIMIT_EVT_I, FAULT_EVT_I}),
        .pulse_o(evt_pulse)
    );

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    reg [15:0] ctrl_r;
    reg [DATA_W-1:0] phase_r;
    reg [DATA_W-1:0] gen_duty_r;
    reg [DATA_W-1:0] mst_period_r;
    reg [DATA_W-1:0] mst_duty_r;
    reg limit_mode_r;
    reg mod_en_r;

    reg waitreq_r;
    reg [31:0] rdata_r;

    reg [DATA_W-1:0] period_r;
    reg [DATA_W-1:0] duty_r;
    reg cam_eff_r;
    reg xpr_eff_r;
    reg [1:0] dtc_r;
    reg deadtime_comp_polarity_eff_r;
    reg tbs_r;
    reg iue_r;
    reg irq_r;

    // ---------------------------------------------------------------
    // bus handshake: one wait cycle, then a single acknowledge cycle
    // ---------------------------------------------------------------
    wire req = AVS_READ_I | AVS_WRITE_I;
    wire waitreq_nxt = ~(req & waitreq_r);
    // a write commits only at the edge where waitrequest is seen low
    wire wr_ack = AVS_WRITE_I & ~waitreq_r;
    wire [5:0] addr = {AVS_ADDRESS_I[5:2], 2'b00};

    wire [31:0] be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                           {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [31:0] mask;
        begin
            merge = (old_v & ~mask) | (new_v & mask);
        end
    endfunction

    reg wr_ctrl;
    reg wr_phase;
    reg wr_gduty;
    reg wr_mper;
    reg wr_mduty;
    reg wr_flim;
    reg wr_moden;

    // address decode for writes; unmapped writes are dropped
    always @*
    begin
        wr_ctrl = 1'b0;
        wr_phase = 1'b0;
        wr_gduty = 1'b0;
        wr_mper = 1'b0;
        wr_mduty = 1'b0;
        wr_flim = 1'b0;
        wr_moden = 1'b0;
        if (addr == `PGC_OFF_CTRL)
            wr_ctrl = wr_ack;
        else if (addr == `PGC_OFF_PHASE)
            wr_phase = wr_ack;
        else if (addr == `PGC_OFF_GEN_DUTY)
            wr_gduty = wr_ack;
        else if (addr == `PGC_OFF_MST_PERIOD)
            wr_mper = wr_ack;
        else if (addr == `PGC_OFF_MST_DUTY)
            wr_mduty = wr_ack;
        else if (addr == `PGC_OFF_FLT_LIM)
            wr_flim = wr_ack;
        else if (addr == `PGC_OFF_MOD_EN)
            wr_moden = wr_ack;
    end

    // ---------------------------------------------------------------
    // control register: software bits, then hardware status bits
    // ---------------------------------------------------------------
    wire [31:0] ctrl_merged = merge({16'h0000, ctrl_r}, AVS_WRITEDATA_I, be_mask);
    reg [15:0] ctrl_nxt;
    wire [2:0] en_nxt;
    wire [2:0] pend_cur;
    wire [2:0] pend_nxt;

    always @*
    begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl)
            ctrl_nxt[12:0] = ctrl_merged[12:0];
        ctrl_nxt[`PGC_CTRL_UNUSED] = 1'b0;
    end

    assign en_nxt = {ctrl_nxt[`PGC_CTRL_TRG_EN], ctrl_nxt[`PGC_CTRL_LIM_EN],
                     ctrl_nxt[`PGC_CTRL_FLT_EN]};
    assign pend_cur = {ctrl_r[`PGC_CTRL_TRG_PEND], ctrl_r[`PGC_CTRL_LIM_PEND],
                       ctrl_r[`PGC_CTRL_FLT_PEND]};

    // a flag is set only while its enable stands; an enable at 0 holds the
    // flag clear, so a disabling write beats an event in the same cycle
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_pend
            assign pend_nxt[g] = en_nxt[g] & (pend_cur[g] | evt_pulse[g]);
        end
    endgenerate

    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ctrl_r <= `PGC_RST_CTRL;
        end
        else
        begin
            // the flag vector runs fault first; the register keeps fault at the top
            ctrl_r <= {pend_nxt[0], pend_nxt[1], pend_nxt[2], ctrl_nxt[12:0]};
        end
    end

    // ---------------------------------------------------------------
    // data registers and module-level bits
    // ---------------------------------------------------------------
    wire [31:0] phase_merged =
        merge({{(32-DATA_W){1'b0}}, phase_r}, AVS_WRITEDATA_I, be_mask);
    wire [31:0] gduty_merged =
        merge({{(32-DATA_W){1'b0}}, gen_duty_r}, AVS_WRITEDATA_I, be_mask);
    wire [31:0] mper_merged =
        merge({{(32-DATA_W){1'b0}}, mst_period_r}, AVS_WRITEDATA_I, be_mask);
    wire [31:0] mduty_merged =
        merge({{(32-DATA_W){1'b0}}, mst_duty_r}, AVS_WRITEDATA_I, be_mask);

    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            phase_r <= `PGC_RST_WORD16;
            gen_duty_r <= `PGC_RST_WORD16;
            mst_period_r <= `PGC_RST_WORD16;
            mst_duty_r <= `PGC_RST_WORD16;
            limit_mode_r <= 1'b0;
            mod_en_r <= 1'b0;
        end
        else
        begin
            if (wr_phase)
                phase_r <= phase_merged[DATA_W-1:0];
            if (wr_gduty)
                gen_duty_r <= gduty_merged[DATA_W-1:0];
            if (wr_mper)
                mst_period_r <= mper_merged[DATA_W-1:0];
            if (wr_mduty)
                mst_duty_r <= mduty_merged[DATA_W-1:0];
            if (wr_flim && AVS_BYTEENABLE_I[0])
                limit_mode_r <= AVS_WRITEDATA_I[`PGC_FLT_LIM_MODE];
            if (wr_moden && AVS_BYTEENABLE_I[0])
                mod_en_r <= AVS_WRITEDATA_I[`PGC_MOD_EN_BIT];
        end
    end

    // ---------------------------------------------------------------
    // derived mode outputs, computed from next-state so they track writes
    // without an extra cycle of lag
    // ---------------------------------------------------------------
    wire itb_nxt = ctrl_nxt[`PGC_CTRL_ITB];
    wire sds_nxt = ctrl_nxt[`PGC_CTRL_SDS];
    wire [1:0] dtc_nxt = ctrl_nxt[`PGC_CTRL_DTC_HI:`PGC_CTRL_DTC_LO];
    wire limit_mode_nxt = (wr_flim && AVS_BYTEENABLE_I[0]) ?
                          AVS_WRITEDATA_I[`PGC_FLT_LIM_MODE] : limit_mode_r;
    wire mod_en_nxt = (wr_moden && AVS_BYTEENABLE_I[0]) ?
                      AVS_WRITEDATA_I[`PGC_MOD_EN_BIT] : mod_en_r;
    wire [DATA_W-1:0] phase_nxt = wr_phase ? phase_merged[DATA_W-1:0] : phase_r;
    wire [DATA_W-1:0] gduty_nxt = wr_gduty ? gduty_merged[DATA_W-1:0] : gen_duty_r;
    wire [DATA_W-1:0] mper_nxt = wr_mper ? mper_merged[DATA_W-1:0] : mst_period_r;
    wire [DATA_W-1:0] mduty_nxt = wr_mduty ? mduty_merged[DATA_W-1:0] : mst_duty_r;

    // mode bits are taken as written even while the module runs; keeping
    // them static then is left to software
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            period_r <= `PGC_RST_WORD16;
            duty_r <= `PGC_RST_WORD16;
            cam_eff_r <= 1'b0;
            xpr_eff_r <= 1'b0;
            dtc_r <= 2'h0;
            deadtime_comp_polarity_eff_r <= 1'b0;
            tbs_r <= 1'b0;
            iue_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            period_r <= itb_nxt ? phase_nxt : mper_nxt;
            duty_r <= sds_nxt ? mduty_nxt : gduty_nxt;
            cam_eff_r <= itb_nxt & ctrl_nxt[`PGC_CTRL_CAM];
            xpr_eff_r <= itb_nxt & ~limit_mode_nxt & ctrl_nxt[`PGC_CTRL_XPR];
            dtc_r <= dtc_nxt;
            deadtime_comp_polarity_eff_r <= (dtc_nxt == `PGC_DTC_COMP) & ctrl_nxt[`PGC_CTRL_DEADTIME_COMP_POLARITY];
            tbs_r <= ctrl_nxt[`PGC_CTRL_TBS];
            iue_r <= ctrl_nxt[`PGC_CTRL_IUE];
            irq_r <= |(pend_nxt & en_nxt);
        end
    end

    reg mod_en_q_r;

    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            mod_en_q_r <= 1'b0;
        else
            mod_en_q_r <= mod_en_nxt;
    end

    // ---------------------------------------------------------------
    // read path: data is loaded at the edge that drops waitrequest
    // ---------------------------------------------------------------
    reg [31:0] rd_mux;

    always @*
    begin
        rd_mux = `PGC_RST_BUS;
        if (addr == `PGC_OFF_CTRL)
            rd_mux = {16'h0000, ctrl_r};
        else if (addr == `PGC_OFF_PHASE)
            rd_mux = {{(32-DATA_W){1'b0}}, phase_r};
        else if (addr == `PGC_OFF_GEN_DUTY)
            rd_mux = {{(32-DATA_W){1'b0}}, gen_duty_r};
        else if (addr == `PGC_OFF_MST_PERIOD)
            rd_mux = {{(32-DATA_W){1'b0}}, mst_period_r};
        else if (addr == `PGC_OFF_MST_DUTY)
            rd_mux = {{(32-DATA_W){1'b0}}, mst_duty_r};
        else if (addr == `PGC_OFF_FLT_LIM)
            rd_mux = {31'h00000000, limit_mode_r};
        else if (addr == `PGC_OFF_MOD_EN)
            rd_mux = {31'h00000000, mod_en_r};
        else if (addr == `PGC_OFF_EFFECT)
            rd_mux = {28'h0000000, irq_r, deadtime_comp_polarity_eff_r, xpr_eff_r, cam_eff_r};
        else if (addr == `PGC_OFF_SELECTED)
            rd_mux = {duty_r, period_r};
    end

    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            waitreq_r <= 1'b1;
            rdata_r <= `PGC_RST_BUS;
        end
        else
        begin
            waitreq_r <= waitreq_nxt;
            if (AVS_READ_I && waitreq_r)
                rdata_r <= rd_mux;
        end
    end

    assign AVS_READDATA_O = rdata_r;
    assign AVS_WAITREQUEST_O = waitreq_r;
    assign PERIOD_O = period_r;
    assign DUTY_O = duty_r;
    assign CENTER_ALIGNED_O = cam_eff_r;
    assign EXT_PERIOD_RESET_O = xpr_eff_r;
    assign DEADTIME_CONTROL_O = dtc_r;
    assign DEADTIME_COMP_POL_O = deadtime_comp_polarity_eff_r;
    assign TIMEBASE_SOURCE_O = tbs_r;
    assign IMMEDIATE_UPDATE_O = iue_r;
    assign PWM_MODULE_ENABLE_O = mod_en_q_r;
    assign IRQ_O = irq_r;

endmodule

`default_nettype wire

// ===== verilog/pgc_map.vh
/*
 * Register map, field positions and reset values of the PWM generator
 * control block. Assumes a 32-bit Avalon-MM slave with byte addresses,
 * one register per aligned word.
 */
`ifndef PGC_MAP_VH
`define PGC_MAP_VH

// register byte offsets
`define PGC_OFF_CTRL        6'h00
`define PGC_OFF_PHASE       6'h04
`define PGC_OFF_GEN_DUTY    6'h08
`define PGC_OFF_MST_PERIOD  6'h0C
`define PGC_OFF_MST_DUTY    6'h10
`define PGC_OFF_FLT_LIM     6'h14
`define PGC_OFF_MOD_EN      6'h18
`define PGC_OFF_EFFECT      6'h1C
`define PGC_OFF_SELECTED    6'h20

// generator control register fields
`define PGC_CTRL_FLT_PEND   15
`define PGC_CTRL_LIM_PEND   14
`define PGC_CTRL_TRG_PEND   13
`define PGC_CTRL_FLT_EN     12
`define PGC_CTRL_LIM_EN     11
`define PGC_CTRL_TRG_EN     10
`define PGC_CTRL_ITB        9
`define PGC_CTRL_SDS        8
`define PGC_CTRL_DTC_HI     7
`define PGC_CTRL_DTC_LO     6
`define PGC_CTRL_DEADTIME_COMP_POLARITY       5
`define PGC_CTRL_UNUSED     4
`define PGC_CTRL_TBS        3
`define PGC_CTRL_CAM        2
`define PGC_CTRL_XPR        1
`define PGC_CTRL_IUE        0

// other fields
`define PGC_FLT_LIM_MODE    0
`define PGC_MOD_EN_BIT      0
`define PGC_EFF_CAM         0
`define PGC_EFF_XPR         1
`define PGC_EFF_DEADTIME_COMP_POLARITY        2
`define PGC_EFF_IRQ         3

// dead-time control code at which the polarity bit is honoured
`define PGC_DTC_COMP        2'h3

// reset values
`define PGC_RST_CTRL        16'h0000
`define PGC_RST_WORD16      16'h0000
`define PGC_RST_BUS         32'h00000000

`endif

// ===== verilog/pgc_evt_sync.v
/*
 * Two-flop synchroniser with rising-edge detector for a group of event pins.
 * Assumes the pins are asynchronous levels held at least two clock periods.
 */
`timescale 1ns/10ps
`default_nettype none

module pgc_evt_sync #(
    parameter WIDTH = 3
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] evt_i,
    output wire [WIDTH-1:0] pulse_o
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;
    reg [WIDTH-1:0] last_r;
    reg [WIDTH-1:0] pulse_r;

    // meta_r is read only by sync_r
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
            last_r <= {WIDTH{1'b0}};
            pulse_r <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_r <= evt_i;
            sync_r <= meta_r;
            last_r <= sync_r;
            pulse_r <= sync_r & ~last_r;
        end
    end

    assign pulse_o = pulse_r;

endmodule

`default_nettype wire

// ===== bench/pgc_top_sva.sv
/*
 * Port-level checker for the PWM generator control block: bus timing,
 * readback consistency, mode gating and interrupt causes.
 * Assumes the register map of pgc_map.vh and one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pgc_map.vh"
module pgc_top_sva #(
    parameter DATA_W = 16
) (
    input wire CLK_I,
    input wire RST_I,
    input wire [5:0] AVS_ADDRESS_I,
    input wire AVS_READ_I,
    input wire AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire [3:0] AVS_BYTEENABLE_I,
    input wire [31:0] AVS_READDATA_O,
    input wire AVS_WAITREQUEST_O,
    input wire FAULT_EVT_I,
    input wire LIMIT_EVT_I,
    input wire TRIGGER_EVT_I,
    input wire [DATA_W-1:0] PERIOD_O,
    input wire [DATA_W-1:0] DUTY_O,
    input wire CENTER_ALIGNED_O,
    input wire EXT_PERIOD_RESET_O,
    input wire [1:0] DEADTIME_CONTROL_O,
    input wire DEADTIME_COMP_POL_O,
    input wire TIMEBASE_SOURCE_O,
    input wire IMMEDIATE_UPDATE_O,
    input wire PWM_MODULE_ENABLE_O,
    input wire IRQ_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);
    wire rd_ack = AVS_READ_I && !AVS_WAITREQUEST_O;
    wire wr_ack = AVS_WRITE_I && !AVS_WAITREQUEST_O;
    wire [3:0] word = AVS_ADDRESS_I[5:2];
    wire ctrl_wr_ack = wr_ack && word == 4'h0;
    wire any_evt = FAULT_EVT_I || LIMIT_EVT_I || TRIGGER_EVT_I;

    a_wait_answer: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
        |=> !AVS_WAITREQUEST_O) else $error("waitrequest did not drop one cycle after request");
    a_wait_single: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait: assert property (!(AVS_READ_I || AVS_WRITE_I) |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low without a request");
    a_comp_pol: assert property (DEADTIME_COMP_POL_O |->
        DEADTIME_CONTROL_O == `PGC_DTC_COMP)
        else $error("dead-time polarity active with wrong control code");
    a_ctrl_resv: assert property (rd_ack && word == 4'h0 |->
        AVS_READDATA_O[4] == 1'b0 && AVS_READDATA_O[31:16] == 16'h0000)
        else $error("reserved control bits read nonzero");
    a_pend_enable: assert property (rd_ack && word == 4'h0 |->
        (AVS_READDATA_O[15:13] & ~AVS_READDATA_O[12:10]) == 3'h0)
        else $error("pending flag set while its enable is 0");
    a_eff_match: assert property (rd_ack && word == 4'h7 |->
        AVS_READDATA_O[2:0] == {DEADTIME_COMP_POL_O, EXT_PERIOD_RESET_O, CENTER_ALIGNED_O})
        else $error("effective mode readback differs from outputs");
    a_sel_match: assert property (rd_ack && word == 4'h8 |->
        AVS_READDATA_O == {DUTY_O, PERIOD_O}) else $error("selected sources differ from outputs");
    a_mode_write: assert property (!$stable({PERIOD_O, DUTY_O, CENTER_ALIGNED_O,
        EXT_PERIOD_RESET_O, DEADTIME_CONTROL_O, DEADTIME_COMP_POL_O, TIMEBASE_SOURCE_O,
        IMMEDIATE_UPDATE_O, PWM_MODULE_ENABLE_O}) |-> $past(wr_ack))
        else $error("mode output changed without a committed write");
    a_irq_fall: assert property ($fell(IRQ_O) |-> $past(ctrl_wr_ack))
        else $error("interrupt dropped without a control write");
    a_irq_rise: assert property ($rose(IRQ_O) |->
        $past(any_evt, 3))
        else $error("interrupt raised without an event");
endmodule
bind pgc_top pgc_top_sva #(.DATA_W(DATA_W)) u_sva (.CLK_I(CLK_I), .RST_I(RST_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .FAULT_EVT_I(FAULT_EVT_I), .LIMIT_EVT_I(LIMIT_EVT_I), .TRIGGER_EVT_I(TRIGGER_EVT_I),
    .PERIOD_O(PERIOD_O), .DUTY_O(DUTY_O), .CENTER_ALIGNED_O(CENTER_ALIGNED_O),
    .EXT_PERIOD_RESET_O(EXT_PERIOD_RESET_O), .DEADTIME_CONTROL_O(DEADTIME_CONTROL_O),
    .DEADTIME_COMP_POL_O(DEADTIME_COMP_POL_O), .TIMEBASE_SOURCE_O(TIMEBASE_SOURCE_O),
    .IMMEDIATE_UPDATE_O(IMMEDIATE_UPDATE_O), .PWM_MODULE_ENABLE_O(PWM_MODULE_ENABLE_O),
    .IRQ_O(IRQ_O));
`default_nettype wire

// ===== bench/tb.sv
/*
 * Self-checking bench for the PWM generator control block: register map,
 * source selection, mode gating and the three pending flags.
 * Assumes a one-wait-cycle Avalon-MM slave and synchronised event pins.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pgc_map.vh"
module tb;
    reg CLK_I = 1'b0;
    reg RST_I = 1'b1;
    reg [5:0] addr = 6'h00;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wdata = 32'h00000000;
    reg [3:0] be = 4'hF;
    reg [2:0] evt = 3'h0;
    wire [31:0] rdata;
    wire wait_req;
    wire [15:0] period;
    wire [15:0] duty;
    wire [1:0] dtc;
    wire center_aligned_mode, xpr, deadtime_comp_polarity, tbs, immediate_update_enable, men, irq;
    integer err_count = 0;
    integer checks_done = 0;
    integer seed = 97902;
    integer i;
    reg [31:0] exp_q[$];
    reg [15:0] ph, gd, mp, md;
    reg [31:0] ctl;

    pgc_top #(.DATA_W(16)) u_dut (.CLK_I(CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req), .FAULT_EVT_I(evt[0]),
        .LIMIT_EVT_I(evt[1]), .TRIGGER_EVT_I(evt[2]), .PERIOD_O(period), .DUTY_O(duty),
        .CENTER_ALIGNED_O(center_aligned_mode), .EXT_PERIOD_RESET_O(xpr), .DEADTIME_CONTROL_O(dtc),
        .DEADTIME_COMP_POL_O(deadtime_comp_polarity), .TIMEBASE_SOURCE_O(tbs), .IMMEDIATE_UPDATE_O(immediate_update_enable),
        .PWM_MODULE_ENABLE_O(men), .IRQ_O(irq));

    initial
    begin
        forever #5 CLK_I = ~CLK_I;
    end

    task check(input [31:0] seen, input [31:0] exp, input [8*8-1:0] name);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("[ERR] %0s expected %h seen %h", name, exp, seen);
        end
    end
    endtask

    // read results arrive in request order, one per acknowledge
    always @(posedge CLK_I)
    begin
        if (rd === 1'b1 && wait_req === 1'b0)
            check(rdata, exp_q.pop_front(), "readdata");
    end

    task bus(input do_wr, input [5:0] a, input [31:0] d, input [3:0] b);
        integer n;
    begin
        n = 0;
        @(posedge CLK_I);
        addr <= a;
        wdata <= d;
        be <= b;
        rd <= ~do_wr;
        wr <= do_wr;
        @(posedge CLK_I);
        while (wait_req !== 1'b0 && n < 50)
        begin
            @(posedge CLK_I);
            n = n + 1;
        end
        if (n >= 50)
            check(32'h1, 32'h0, "waitreq");
        rd <= 1'b0;
        wr <= 1'b0;
    end
    endtask

    task wrt(input [5:0] a, input [31:0] d);
    begin
        bus(1'b1, a, d, 4'hF);
    end
    endtask

    task rdx(input [5:0] a, input [31:0] e);
    begin
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, 4'hF);
    end
    endtask

    // pin held three cycles, then low long enough for the flag to land
    task pulse(input integer k);
    begin
        @(posedge CLK_I);
        evt[k] <= 1'b1;
        repeat (3) @(posedge CLK_I);
        evt[k] <= 1'b0;
        repeat (8) @(posedge CLK_I);
    end
    endtask

    task summarize;
    begin
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    initial
    begin
        #200000;
        check(32'h1, 32'h0, "watchdog");
        summarize;
    end

    initial
    begin
        repeat (12) @(posedge CLK_I);
        RST_I <= 1'b0;
        for (i = 0; i < 9; i = i + 1)
            rdx(i * 4, 32'h0);
        wrt(`PGC_OFF_CTRL, 32'hFFFFFFFF);
        rdx(`PGC_OFF_CTRL, 32'h00001FEF);
        #1 check({tbs, immediate_update_enable, dtc}, 4'hF, "modes");
        rdx(`PGC_OFF_EFFECT, 32'h7);
        wrt(6'h24, 32'hFFFF);
        rdx(6'h24, 32'h0);
        rdx(6'h3C, 32'h0);
        // module enable stays 0 while mode bits move
        for (i = 0; i < 32; i = i + 1)
        begin
            ctl = {22'h0, i[0], 1'b0, i[3:2], 3'b100, i[1], 2'b10};
            wrt(`PGC_OFF_CTRL, ctl);
            wrt(`PGC_OFF_FLT_LIM, {31'h0, i[4]});
            rdx(`PGC_OFF_EFFECT,
                {29'h0, i[3:2] == 2'h3, i[0] & ~i[4], i[0] & i[1]});
        end
        ph = $random(seed);
        gd = $random(seed);
        mp = $random(seed);
        md = $random(seed);
        wrt(`PGC_OFF_PHASE, {16'h0, ph});
        wrt(`PGC_OFF_GEN_DUTY, {16'h0, gd});
        wrt(`PGC_OFF_MST_PERIOD, {16'h0, mp});
        wrt(`PGC_OFF_MST_DUTY, {16'h0, md});
        for (i = 0; i < 4; i = i + 1)
        begin
            wrt(`PGC_OFF_CTRL, {22'h0, i[1:0], 8'h00});
            rdx(`PGC_OFF_SELECTED, {i[0] ? md : gd, i[1] ? ph : mp});
            #1 check({16'h0, period}, {16'h0, i[1] ? ph : mp}, "period");
            check({16'h0, duty}, {16'h0, i[0] ? md : gd}, "duty");
        end
        bus(1'b1, `PGC_OFF_PHASE, 32'h0000ABCD, 4'b0001);
        rdx(`PGC_OFF_PHASE, {16'h0, ph[15:8], 8'hCD});
        wrt(`PGC_OFF_MOD_EN, 32'h1);
        #1 check({31'h0, men}, 32'h1, "enable");
        wrt(`PGC_OFF_MOD_EN, 32'h0);
        for (i = 0; i < 3; i = i + 1)
        begin
            wrt(`PGC_OFF_CTRL, 32'h1C00);
            pulse(i);
            rdx(`PGC_OFF_CTRL, 32'h1C00 | (32'h8000 >> i));
            #1 check({31'h0, irq}, 32'h1, "irq");
            ctl = 32'h1C00 & ~(32'h1000 >> i);
            wrt(`PGC_OFF_CTRL, ctl);
            rdx(`PGC_OFF_CTRL, ctl);
            #1 check({31'h0, irq}, 32'h0, "irq");
            pulse(i);
            rdx(`PGC_OFF_CTRL, ctl);
        end
        summarize;
    end
endmodule
`default_nettype wire
